// ### bfpm_ctrl.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Host-side sequencer for binary field point multiply and point add
module bfpm_ctrl #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine register port
  output logic eng_sel,
  output logic eng_write,
  output logic [7:0] eng_addr,
  output logic [31:0] eng_wdata,
  input wire logic [31:0] eng_rdata,
  input wire logic eng_ack,
  // Engine readiness pin
  input wire logic multiplier_ready_pin_n
);
  import bfpm_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bfpm_state_type state_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic eng_sel_q;
  logic eng_write_q;
  logic [7:0] eng_addr_q;
  logic [31:0] eng_wdata_q;
  logic proj_q;
  logic padd_q;
  logic poll_q;
  logic [7:0] modsize_q;
  logic [7:0] pass_addr_q;
  logic [31:0] pass_rdata_q;
  logic [AW:0] kptr_q;
  logic [AW:0] idx_q;
  logic nz_prefix_q;
  logic [31:0] last_word_q;
  logic busy_q;
  logic done_q;
  logic err_q;
  logic [31:0] kmem_rdata;
  logic acc_fire;
  logic wr_fire;
  logic start_req;
  logic kword_wr;
  logic pass_wr_req;
  logic pass_rd_req;
  logic start_ok;
  logic [7:0] start_modsize;
  logic [31:0] rd_mux;
  logic addr_ok;

  // Engine control word with go, select, entry and size
  function automatic logic [31:0] eng_ctrl_word(input logic proj,
      input logic padd, input logic [7:0] msize);
    logic [31:0] w;
    w = BFPM_DATA_RST;
    w[BFPM_ENG_GO_BIT] = 1'b1;
    w[BFPM_ENG_PROJ_BIT] = proj; // R11
    w[BFPM_ENG_ENTRY_POS +: 8] = padd ? BFPM_ENTRY_PADD
                                      : BFPM_ENTRY_MULT; // R17
    w[BFPM_ENG_MODSIZE_POS +: 8] = msize;
    return w;
  endfunction

  // Decode whether an APB offset is mapped
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == BFPM_CTRL_OFF) || (a == BFPM_STATUS_OFF) ||
           (a == BFPM_KWORD_OFF) || (a == BFPM_PASS_ADDR_OFF) ||
           (a == BFPM_PASS_DATA_OFF);
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // Writes take effect on the completing edge; read data is registered one edge earlier
  assign acc_fire = psel && penable && pready_q;
  assign addr_ok = is_mapped(paddr);
  assign wr_fire = acc_fire && pwrite && addr_ok;
  assign start_req = wr_fire && (paddr == BFPM_CTRL_OFF) &&
                     pwdata[BFPM_CTRL_START_BIT];
  assign kword_wr = wr_fire && (paddr == BFPM_KWORD_OFF) && !busy_q &&
                    (kptr_q != (AW+1)'(DEPTH));
  assign pass_wr_req = wr_fire && (paddr == BFPM_PASS_DATA_OFF);
  assign pass_rd_req = wr_fire && (paddr == BFPM_PASS_ADDR_OFF) &&
                       pwdata[BFPM_PASS_RD_BIT];
  assign start_modsize = pwdata[BFPM_CTRL_MODSIZE_POS +: BFPM_CTRL_MODSIZE_W];

  // Refuse a multiply that cannot give a correct result
  assign start_ok = pwdata[BFPM_CTRL_PADD_BIT] ||
                    ((start_modsize >= BFPM_MODSIZE_MIN) && // R16
                     (kptr_q != '0) &&
                     (nz_prefix_q || (last_word_q > 32'h0000_0001))); // R15

  // Read multiplexer
  always_comb begin
    rd_mux = BFPM_DATA_RST;
    unique case (paddr)
      BFPM_CTRL_OFF: begin
        rd_mux[BFPM_CTRL_PROJ_BIT] = proj_q;
        rd_mux[BFPM_CTRL_PADD_BIT] = padd_q;
        rd_mux[BFPM_CTRL_POLL_BIT] = poll_q;
        rd_mux[BFPM_CTRL_MODSIZE_POS +: BFPM_CTRL_MODSIZE_W] = modsize_q;
      end
      BFPM_STATUS_OFF: begin
        rd_mux[BFPM_STAT_BUSY_BIT] = busy_q;
        rd_mux[BFPM_STAT_DONE_BIT] = done_q;
        rd_mux[BFPM_STAT_ERR_BIT] = err_q;
        rd_mux[BFPM_STAT_LOADED_POS +: 8] = 8'(kptr_q);
        rd_mux[BFPM_STAT_SENT_POS +: 8] = 8'(idx_q);
      end
      BFPM_PASS_ADDR_OFF: rd_mux[7:0] = pass_addr_q;
      BFPM_PASS_DATA_OFF: rd_mux = pass_rdata_q;
      default: rd_mux = BFPM_DATA_RST; // Key store is write only
    endcase
  end

  // One wait state per access keeps every output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= BFPM_DATA_RST;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !addr_ok;
      prdata_q <= (pwrite || !addr_ok) ? BFPM_DATA_RST : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Stored configuration; held steady while a run is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proj_q <= 1'b0;
      padd_q <= 1'b0;
      poll_q <= 1'b0;
      modsize_q <= BFPM_MODSIZE_RST;
      pass_addr_q <= 8'h00;
    end else if (wr_fire && !busy_q) begin
      if (paddr == BFPM_CTRL_OFF) begin
        proj_q <= pwdata[BFPM_CTRL_PROJ_BIT]; // R11
        padd_q <= pwdata[BFPM_CTRL_PADD_BIT];
        poll_q <= pwdata[BFPM_CTRL_POLL_BIT]; // R09
        modsize_q <= start_modsize;
      end
      if (paddr == BFPM_PASS_ADDR_OFF) begin
        pass_addr_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Scalar store, loaded most significant word first
  // ----------------------------------------------------------------

  // Track whether the loaded scalar exceeds one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kptr_q <= '0;
      nz_prefix_q <= 1'b0;
      last_word_q <= BFPM_DATA_RST;
    end else if (wr_fire && !busy_q && (paddr == BFPM_CTRL_OFF) &&
                 pwdata[BFPM_CTRL_REWIND_BIT]) begin
      kptr_q <= '0;
      nz_prefix_q <= 1'b0;
      last_word_q <= BFPM_DATA_RST;
    end else if (kword_wr) begin
      kptr_q <= kptr_q + (AW+1)'(1); // R05
      nz_prefix_q <= nz_prefix_q ||
                     ((kptr_q != '0) && (last_word_q != BFPM_DATA_RST));
      last_word_q <= pwdata;
    end
  end

  bfpm_kmem #(
    .WIDTH(32),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_kmem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(kword_wr),
    .wr_addr(kptr_q[AW-1:0]),
    .wr_data(pwdata),
    .rd_addr(idx_q[AW-1:0]),
    .rd_data_q(kmem_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // Engine strobe held until the engine acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= BFPM_S_IDLE;
      eng_sel_q <= 1'b0;
      eng_write_q <= 1'b0;
      eng_addr_q <= 8'h00;
      eng_wdata_q <= BFPM_DATA_RST;
      idx_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      pass_rdata_q <= BFPM_DATA_RST;
    end else begin
      unique case (state_q)
        BFPM_S_IDLE: begin
          if (start_req) begin
            done_q <= 1'b0;
            err_q <= !start_ok;
            if (start_ok) begin
              // Control written first so no word precedes go
              busy_q <= 1'b1;
              idx_q <= '0;
              eng_sel_q <= 1'b1; // R10
              eng_write_q <= 1'b1;
              eng_addr_q <= BFPM_ENG_CTRL_OFF;
              eng_wdata_q <= eng_ctrl_word(pwdata[BFPM_CTRL_PROJ_BIT],
                                           pwdata[BFPM_CTRL_PADD_BIT],
                                           start_modsize);
              state_q <= BFPM_S_WR_CTRL;
            end
          end else if (pass_wr_req) begin
            // Operand load; values arrive from software as prepared
            eng_sel_q <= 1'b1; // R01 R02 R03 R18 R20
            eng_write_q <= 1'b1;
            eng_addr_q <= pass_addr_q;
            eng_wdata_q <= pwdata;
            state_q <= BFPM_S_PASS;
          end else if (pass_rd_req) begin
            // Result readback, e.g. Z powers for host inversion
            eng_sel_q <= 1'b1; // R12 R13 R14 R19
            eng_write_q <= 1'b0;
            eng_addr_q <= pwdata[7:0];
            state_q <= BFPM_S_PASS;
          end
        end
        BFPM_S_PASS: begin
          if (eng_ack) begin
            eng_sel_q <= 1'b0;
            if (!eng_write_q) begin
              pass_rdata_q <= eng_rdata;
            end
            state_q <= BFPM_S_IDLE;
          end
        end
        BFPM_S_WR_CTRL: begin
          if (eng_ack) begin
            eng_sel_q <= 1'b0;
            // Point add needs no scalar; just wait for completion
            state_q <= (padd_q || poll_q) ? BFPM_S_STAT_GO
                                          : BFPM_S_WAIT_RDY;
          end
        end
        BFPM_S_WAIT_RDY: begin
          if (!multiplier_ready_pin_n) begin
            eng_sel_q <= 1'b1; // R07 R08
            eng_write_q <= 1'b1;
            eng_addr_q <= BFPM_ENG_MULT_OFF;
            eng_wdata_q <= kmem_rdata; // R04 R06
            state_q <= BFPM_S_WR_WORD;
          end
        end
        BFPM_S_WR_WORD: begin
          if (eng_ack) begin
            eng_sel_q <= 1'b0;
            idx_q <= idx_q + (AW+1)'(1);
            state_q <= poll_q ? BFPM_S_STAT_GO : BFPM_S_WAIT_CONS;
          end
        end
        BFPM_S_WAIT_CONS: begin
          // Pin must drop its request before the next word goes
          if (multiplier_ready_pin_n) begin // R21
            state_q <= (idx_q == kptr_q) ? BFPM_S_STAT_GO
                                         : BFPM_S_WAIT_RDY;
          end
        end
        BFPM_S_STAT_GO: begin
          eng_sel_q <= 1'b1;
          eng_write_q <= 1'b0;
          eng_addr_q <= BFPM_ENG_STATUS_OFF;
          state_q <= BFPM_S_STAT;
        end
        BFPM_S_STAT: begin
          if (eng_ack) begin
            eng_sel_q <= 1'b0;
            if (eng_rdata[BFPM_ENG_DONE_BIT]) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= BFPM_S_IDLE;
            end else if (!padd_q && (idx_q != kptr_q) &&
                         eng_rdata[BFPM_ENG_READY_BIT]) begin
              eng_sel_q <= 1'b1; // R09 R08
              eng_write_q <= 1'b1;
              eng_addr_q <= BFPM_ENG_MULT_OFF;
              eng_wdata_q <= kmem_rdata; // R06
              state_q <= BFPM_S_WR_WORD;
            end else begin
              state_q <= BFPM_S_STAT_GO;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign eng_sel = eng_sel_q;
  assign eng_write = eng_write_q;
  assign eng_addr = eng_addr_q;
  assign eng_wdata = eng_wdata_q;

endmodule // bfpm_ctrl

// ### bfpm_pkg.sv
// What this block does
// R01: Host loads base point untransformed
// R02: Host loads a, c, modulus untransformed
// R03: Host supplies R squared mod N
// R04: Scalar streamed as 32-bit words while running
// R05: Scalar words sent most significant first
// R06: Bits within a word kept msb first
// R07: Engine flags and pins readiness for word
// R08: One scalar word written per readiness
// R09: Masked interrupt means polling status register
// R10: Words before start are ignored by engine
// R11: Select bit picks affine or projective
// R12: Affine results stay in Montgomery domain
// R13: Projective results leave B converted back
// R14: Host inverts Z squared and Z cubed
// R15: Scalar must be greater than one
// R16: Modulus size setting at least four; the code checks this for multiply only and starts a point add with any size
// R17: Point add startable alone for debug
// R18: Point add needs Montgomery operands preloaded
// R19: Point add keeps A0-A3, B0 intact
// R20: Host derives c from b and m
// R21: Readiness clears after word written
package bfpm_pkg;

  // ----------------------------------------------------------------
  // Own register map, byte offsets on APB
  // ----------------------------------------------------------------
  localparam logic [11:0] BFPM_CTRL_OFF = 12'h000;
  localparam logic [11:0] BFPM_STATUS_OFF = 12'h004;
  localparam logic [11:0] BFPM_KWORD_OFF = 12'h008;
  localparam logic [11:0] BFPM_PASS_ADDR_OFF = 12'h00C;
  localparam logic [11:0] BFPM_PASS_DATA_OFF = 12'h010;

  // Control register fields
  localparam int BFPM_CTRL_START_BIT = 0;
  localparam int BFPM_CTRL_PROJ_BIT = 1;
  localparam int BFPM_CTRL_PADD_BIT = 2;
  localparam int BFPM_CTRL_POLL_BIT = 3;
  localparam int BFPM_CTRL_REWIND_BIT = 4;
  localparam int BFPM_CTRL_MODSIZE_POS = 8;
  localparam int BFPM_CTRL_MODSIZE_W = 8;

  // Status register fields
  localparam int BFPM_STAT_BUSY_BIT = 0;
  localparam int BFPM_STAT_DONE_BIT = 1;
  localparam int BFPM_STAT_ERR_BIT = 2;
  localparam int BFPM_STAT_LOADED_POS = 8;
  localparam int BFPM_STAT_SENT_POS = 16;

  // Pass-through address register: read request flag
  localparam int BFPM_PASS_RD_BIT = 31;

  // Reset values and minimum modulus size
  localparam logic [31:0] BFPM_DATA_RST = 32'h0000_0000;
  localparam logic [7:0] BFPM_MODSIZE_RST = 8'h00;
  localparam logic [7:0] BFPM_MODSIZE_MIN = 8'h04;

  // ----------------------------------------------------------------
  // Engine side map
  // ----------------------------------------------------------------
  localparam logic [7:0] BFPM_ENG_CTRL_OFF = 8'h00;
  localparam logic [7:0] BFPM_ENG_STATUS_OFF = 8'h04;
  localparam logic [7:0] BFPM_ENG_MULT_OFF = 8'h08;
  localparam int BFPM_ENG_GO_BIT = 0;
  localparam int BFPM_ENG_PROJ_BIT = 1;
  localparam int BFPM_ENG_ENTRY_POS = 4;
  localparam int BFPM_ENG_MODSIZE_POS = 16;
  localparam int BFPM_ENG_READY_BIT = 0;
  localparam int BFPM_ENG_DONE_BIT = 1;
  localparam logic [7:0] BFPM_ENTRY_MULT = 8'h01;
  localparam logic [7:0] BFPM_ENTRY_PADD = 8'h05;

  // Sequencer states
  typedef enum logic [3:0] {
    BFPM_S_IDLE,
    BFPM_S_PASS,
    BFPM_S_WR_CTRL,
    BFPM_S_WAIT_RDY,
    BFPM_S_WR_WORD,
    BFPM_S_WAIT_CONS,
    BFPM_S_STAT_GO,
    BFPM_S_STAT
  } bfpm_state_type;

endpackage

// ### bfpm_kmem.sv
`timescale 1ns/10ps
// Scalar word store, registered read
module bfpm_kmem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array has no reset; contents are undefined until loaded
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data always from a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule // bfpm_kmem

// ### bfpm_eng_model.sv
`timescale 1ns/10ps
// Behavioural engine: go, scalar word intake, status, readiness pin
module bfpm_eng_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register port from the controller
  input wire logic eng_sel,
  input wire logic eng_write,
  input wire logic [7:0] eng_addr,
  input wire logic [31:0] eng_wdata,
  output logic [31:0] eng_rdata,
  output logic eng_ack,
  output logic multiplier_ready_pin_n,
  // Pacing set by the bench
  input wire logic [3:0] ack_lat,
  input wire logic [7:0] k_words
);
  import bfpm_pkg::*;
  logic [31:0] ctrl_seen, oper_seen;
  logic [31:0] words [0:7];
  logic run_q, rdy_q, done_q, padd_q;
  int wcnt, ngo, lat, work;

  // Pin and status flag come from one bit
  assign multiplier_ready_pin_n = !rdy_q;

  // Access handling; read data churns when not acked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {eng_ack, eng_rdata, ctrl_seen, oper_seen} <= '0;
      {run_q, rdy_q, done_q, padd_q} <= '0;
      {wcnt, ngo, lat, work} <= '0;
    end else begin
      eng_ack <= 1'b0;
      eng_rdata <= ~eng_rdata;
      if (work > 1) begin
        work <= work - 1;
      end else if (work == 1) begin
        work <= 0;
        if (!padd_q && wcnt < k_words) begin
          rdy_q <= 1'b1;
        end else begin
          done_q <= 1'b1;
          run_q <= 1'b0;
        end
      end
      if (eng_sel && !eng_ack && lat < ack_lat) begin
        lat <= lat + 1;
      end else if (eng_sel && !eng_ack) begin
        lat <= 0;
        eng_ack <= 1'b1;
        if (!eng_write) begin
          eng_rdata <= {30'h0, done_q, rdy_q};
        end else if (eng_addr == BFPM_ENG_CTRL_OFF && eng_wdata[0]) begin
          ctrl_seen <= eng_wdata;
          ngo <= ngo + 1;
          {run_q, done_q, wcnt, work} <= {1'b1, 1'b0, 32'd0, 32'd4};
          padd_q <= eng_wdata[11:4] == BFPM_ENTRY_PADD;
        end else if (eng_addr == BFPM_ENG_MULT_OFF && run_q && rdy_q) begin
          // Words outside a run are dropped; one word per readiness
          words[wcnt[2:0]] <= eng_wdata;
          wcnt <= wcnt + 1;
          rdy_q <= 1'b0;
          work <= 3;
        end else if (eng_addr != BFPM_ENG_MULT_OFF) begin
          // Operand store; the host prepares every value itself
          oper_seen <= eng_wdata;
        end
      end
    end
  end
endmodule // bfpm_eng_model

// ### bfpm_chk.sv
`timescale 1ns/10ps
// Port-level checks of the controller
module bfpm_chk
  import bfpm_pkg::*;
#(parameter int DEPTH = 32, parameter int AW = 5) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Engine side
  input wire logic eng_sel,
  input wire logic eng_write,
  input wire logic [7:0] eng_addr,
  input wire logic [31:0] eng_wdata,
  input wire logic [31:0] eng_rdata,
  input wire logic eng_ack,
  input wire logic multiplier_ready_pin_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire eng_go = eng_sel && eng_write && eng_addr == BFPM_ENG_CTRL_OFF
    && eng_wdata[0];

  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_wait1; psel && penable && !pready |=> pready; endproperty
  a_wait1: assert property (p_wait1) else $error("pready late");
  property p_slverr;
    pslverr |-> pready && !(paddr inside {12'h000, 12'h004, 12'h008,
      12'h00C, 12'h010});
  endproperty
  a_slverr: assert property (p_slverr) else $error("bad pslverr");
  property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write prdata");
  property p_eng_hold;
    eng_sel && !eng_ack |=> eng_sel && $stable(eng_addr)
      && $stable(eng_wdata) && $stable(eng_write);
  endproperty
  a_eng_hold: assert property (p_eng_hold) else $error("engine req moved");
  property p_eng_drop;
    eng_sel && eng_ack && eng_addr != BFPM_ENG_STATUS_OFF |=> !eng_sel;
  endproperty
  a_eng_drop: assert property (p_eng_drop) else $error("sel kept");
  property p_word_rdy;
    eng_sel && eng_write && eng_addr == BFPM_ENG_MULT_OFF && !$past(eng_sel)
      |-> !$past(multiplier_ready_pin_n);
  endproperty
  a_word_rdy: assert property (p_word_rdy) else $error("word unasked");
  property p_entry; eng_go |-> eng_wdata[11:4] inside {8'h01, 8'h05};
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry");
  property p_mod;
    eng_go && eng_wdata[11:4] == 8'h01 |-> eng_wdata[23:16] >= 8'h04;
  endproperty
  a_mod: assert property (p_mod) else $error("modsize low");
  property p_padd_go;
    pready && pwrite && paddr == 12'h000 && pwdata[0] && pwdata[2]
      |-> ##[1:3] eng_go;
  endproperty
  a_padd_go: assert property (p_padd_go) else $error("no go");
endmodule // bfpm_chk

bind bfpm_ctrl bfpm_chk #(.DEPTH(DEPTH), .AW(AW)) u_bfpm_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .eng_sel(eng_sel),
  .eng_write(eng_write), .eng_addr(eng_addr), .eng_wdata(eng_wdata),
  .eng_rdata(eng_rdata), .eng_ack(eng_ack),
  .multiplier_ready_pin_n(multiplier_ready_pin_n));

// ### bfpm_ctrl_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
// Bench: APB tasks drive runs against the engine model
module bfpm_ctrl_bench;
  import bfpm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, eng_wdata, eng_rdata;
  logic pready, pslverr, eng_sel, eng_write, eng_ack, pin_n;
  logic [7:0] eng_addr, k_words = '0;
  logic [3:0] ack_lat = '0;
  logic [31:0] kw [0:4];
  int bad_count = 0, check_count = 0, i, j;

  always #5 pclk = ~pclk;

  bfpm_ctrl #(.DEPTH(4), .AW(2)) u_bfpm_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_sel(eng_sel), .eng_write(eng_write),
    .eng_addr(eng_addr), .eng_wdata(eng_wdata), .eng_rdata(eng_rdata),
    .eng_ack(eng_ack), .multiplier_ready_pin_n(pin_n));
  bfpm_eng_model u_bfpm_eng_model (.pclk(pclk), .presetn(presetn),
    .eng_sel(eng_sel), .eng_write(eng_write), .eng_addr(eng_addr),
    .eng_wdata(eng_wdata), .eng_rdata(eng_rdata), .eng_ack(eng_ack),
    .multiplier_ready_pin_n(pin_n), .ack_lat(ack_lat), .k_words(k_words));

  task test_done;
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer, then an idle cycle so no signal is driven twice
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin `CHK("pready", 1'b1, pready); test_done; end
    rd = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask

  // Poll status until the run is over, bounded
  task wait_idle;
    int n;
    n = 0;
    do begin apb(0, BFPM_STATUS_OFF, 0); n++; end
    while (rd[0] !== 1'b0 && n < 300);
    if (rd[0] !== 1'b0) begin `CHK("busy", 1'b0, rd[0]); test_done; end
  endtask

  // Rewind, load words, start, wait
  task run(input logic [31:0] ctl, input int n);
    int k;
    k_words <= n[7:0];
    apb(1, BFPM_CTRL_OFF, 32'h0000_0010);
    for (k = 0; k < n; k++) apb(1, BFPM_KWORD_OFF, kw[k]);
    apb(1, BFPM_CTRL_OFF, ctl);
    wait_idle;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, BFPM_CTRL_OFF, 0);
    `CHK("ctrl reset", 32'h0, rd);
    apb(0, BFPM_STATUS_OFF, 0);
    `CHK("status reset", 32'h0, rd);
    apb(0, 12'h020, 0);
    `CHK("unmapped err", 1'b1, perr);
    `CHK("unmapped data", 32'h0, rd);
    kw = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5};
    run(32'h0000_0301, 5);
    `CHK("small modsize", 3'b100, rd[2:0]);
    `CHK("store full", 8'h04, rd[15:8]);
    kw = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
    run(32'h0000_0401, 2);
    `CHK("scalar one", 3'b100, rd[2:0]);
    `CHK("no go", 0, u_bfpm_eng_model.ngo);
    // Pin mode projective prompt, then poll mode affine slow
    for (j = 0; j < 2; j++) begin
      ack_lat <= j ? 4'h3 : 4'h0;
      kw[0] = j ? 32'h0 : 32'h8000_0001;
      kw[2] = j ? 32'h2 : 32'hFFFF_FFFE;
      run(j ? 32'h0000_0409 : 32'h0000_0403, 3);
      `CHK("status", 32'h0003_0302, rd);
      `CHK("eng ctrl", j ? 32'h0004_0011 : 32'h0004_0013,
        u_bfpm_eng_model.ctrl_seen);
      `CHK("word count", 3, u_bfpm_eng_model.wcnt);
      for (i = 0; i < 3; i++)
        `CHK("word", kw[i], u_bfpm_eng_model.words[i]);
      apb(0, BFPM_CTRL_OFF, 0);
      `CHK("ctrl back", j ? 32'h0000_0408 : 32'h0000_0402, rd);
    end
    ack_lat <= 4'h1;
    run(32'h0000_0005, 0);
    `CHK("padd done", 3'b010, rd[2:0]);
    `CHK("padd entry", BFPM_ENTRY_PADD,
      u_bfpm_eng_model.ctrl_seen[11:4]);
    // Operand load and engine status readback through the pass-through window
    apb(1, BFPM_PASS_ADDR_OFF, 32'h0000_0020);
    apb(1, BFPM_PASS_DATA_OFF, 32'h0000_1234);
    apb(0, BFPM_PASS_ADDR_OFF, 0);
    `CHK("pass addr", 32'h0000_0020, rd);
    `CHK("mapped err", 1'b0, perr);
    `CHK("operand", 32'h0000_1234, u_bfpm_eng_model.oper_seen);
    apb(1, BFPM_PASS_ADDR_OFF, 32'h8000_0004);
    i = 0;
    do begin apb(0, BFPM_PASS_DATA_OFF, 0); i++; end
    while (rd !== 32'h2 && i < 20);
    `CHK("pass status", 32'h2, rd);
    test_done;
  end
endmodule // bfpm_ctrl_bench
